//--- logic/motor_ctrl_pkg.sv
// constants shared by the motor preset and alarm control block
package motor_ctrl_pkg;
    // clock and time base
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned OVERLOAD_UNIT_MS = 100;      // overload threshold unit, 0.1 s
    localparam int unsigned COMM_UNIT_MS     = 1;        // timeout setting unit, 1 ms
    localparam int unsigned BLINK_HALF_MS    = 250;      // alarm led half period
    localparam int unsigned OVERLOAD_UNIT_CYC = CLK_HZ / 1000 * OVERLOAD_UNIT_MS;
    localparam int unsigned COMM_UNIT_CYC     = CLK_HZ / 1000 * COMM_UNIT_MS;
    localparam int unsigned BLINK_HALF_CYC    = CLK_HZ / 1000 * BLINK_HALF_MS;

    // register byte offsets
    localparam logic [7:0] REG_PRESET_POS   = 8'h00;
    localparam logic [7:0] REG_OVERLOAD_THR = 8'h04;
    localparam logic [7:0] REG_DEV_ON_THR   = 8'h08;
    localparam logic [7:0] REG_DEV_OFF_THR  = 8'h0C;
    localparam logic [7:0] REG_CONFIG       = 8'h10;
    localparam logic [7:0] REG_COMM_TIMEOUT = 8'h14;
    localparam logic [7:0] REG_COMM_ERR_LIM = 8'h18;
    localparam logic [7:0] REG_STATUS       = 8'h1C;
    localparam logic [7:0] REG_CMD_POS      = 8'h20;
    localparam logic [7:0] REG_COMM_ERR_CNT = 8'h24;

    // field widths
    localparam int POS_W  = 24;
    localparam int OVL_W  = 9;
    localparam int DEV_W  = 15;
    localparam int TMO_W  = 14;
    localparam int ERR_W  = 4;
    localparam int ALM_W  = 7;

    // reset values
    localparam logic [POS_W-1:0] PRESET_POS_RST   = 24'h000000;
    localparam logic [OVL_W-1:0] OVERLOAD_THR_RST = 9'h032;    // 50 x 0.1 s
    localparam logic [DEV_W-1:0] DEV_ON_THR_RST   = 15'h012C;  // 300 x 0.01 rev
    localparam logic [DEV_W-1:0] DEV_OFF_THR_RST  = 15'h2710;  // 10,000 x 0.01 rev
    localparam logic [TMO_W-1:0] COMM_TIMEOUT_RST = 14'h0000;  // monitoring off
    localparam logic [ERR_W-1:0] COMM_ERR_LIM_RST = 4'h3;
    localparam logic [2:0]       CONFIG_RST       = 3'h0;

    // config register bits
    localparam int CFG_RTH_EN     = 0;
    localparam int CFG_UNLOCK_DIR = 1;
    localparam int CFG_UNLOCK_REM = 2;

    // alarm bit positions
    localparam int ALM_OVERLOAD  = 0;
    localparam int ALM_DEV_ON    = 1;
    localparam int ALM_HOME      = 2;
    localparam int ALM_DEV_OFF   = 3;
    localparam int ALM_COMM_TMO  = 4;
    localparam int ALM_COMM_ERR  = 5;
    localparam int ALM_ABS_POS   = 6;
    // alarms that the fault clear input may clear
    localparam logic [ALM_W-1:0] RESETTABLE_MASK = 7'h3F;

    // status register bit positions above the alarm field
    localparam int ST_WARN   = 8;
    localparam int ST_CURR   = 9;
    localparam int ST_MOTION = 10;
    localparam int ST_UNLOCK = 11;

    // edge detector lanes
    localparam int EDGE_PRESET = 0;
    localparam int EDGE_CLEAR  = 1;
    localparam int EDGE_ABSCLR = 2;
    localparam int EDGE_EXCITE = 3;
    localparam int EDGE_N      = 4;
endpackage

//--- logic/edge_detect.sv
// registered-history edge detector for a group of synchronous inputs
`timescale 1ns/10ps
module edge_detect #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             ce,
    // sampled levels and their edges
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] prev_q;

    // previous sample; starts low so a level already high at reset counts as a rise
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            prev_q <= '0;
        else if (ce)
            prev_q <= din;
    end

    // gated by ce so an edge is seen in exactly one enabled cycle
    assign rise = ce ? (din & ~prev_q) : '0;
    assign fall = ce ? (~din & prev_q) : '0;
endmodule // edge_detect

//--- logic/motor_preset_alarm_control.sv
// command position preset, alarm evaluation and clearing, tool unlock gating
`timescale 1ns/10ps
module motor_preset_alarm_control #(
    parameter int unsigned OVERLOAD_UNIT_CYC = motor_ctrl_pkg::OVERLOAD_UNIT_CYC,
    parameter int unsigned COMM_UNIT_CYC     = motor_ctrl_pkg::COMM_UNIT_CYC,
    parameter int unsigned BLINK_HALF_CYC    = motor_ctrl_pkg::BLINK_HALF_CYC
) (
    // clock, reset, enable
    input  wire logic        CLK,
    input  wire logic        NRST,
    input  wire logic        CE,
    // register port
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    // discrete control inputs
    input  wire logic        PRESET_IN,
    input  wire logic        FAULT_CLEAR_IN,
    input  wire logic        ABS_POSITION_FAULT_CLEAR_IN,
    input  wire logic        TOOL_UNLOCK_DIRECT_IN,
    input  wire logic        TOOL_UNLOCK_REMOTE_IN,
    input  wire logic        EXCITE_IN,
    // motion engine and sensing
    input  wire logic        MOTION_IN,
    input  wire logic        OVERLOAD_IN,
    input  wire logic [14:0] DEVIATION_IN,
    input  wire logic        POSITIONING_START_IN,
    input  wire logic        ORIGIN_SET_IN,
    input  wire logic        ABS_POSITION_ERROR_IN,
    // serial link events
    input  wire logic        COMM_ACTIVITY_IN,
    input  wire logic        COMM_ERROR_IN,
    // outputs
    output logic [23:0]      CMD_POSITION_OUT,
    output logic             FAULT_DIRECT_OUT,
    output logic             FAULT_REMOTE_OUT,
    output logic             ALARM_LED_OUT,
    output logic             MOTOR_CURRENT_OUT,
    output logic             MOTION_ACTIVE_OUT,
    output logic             DEV_OFF_WARN_OUT,
    output logic             TOOL_PERMIT_OUT
);
    localparam int ALM_W = motor_ctrl_pkg::ALM_W;

    // configuration registers
    logic [motor_ctrl_pkg::POS_W-1:0] preset_pos_q;
    logic [motor_ctrl_pkg::OVL_W-1:0] overload_thr_q;
    logic [motor_ctrl_pkg::DEV_W-1:0] dev_on_thr_q;
    logic [motor_ctrl_pkg::DEV_W-1:0] dev_off_thr_q;
    logic [2:0]                       config_q;
    logic [motor_ctrl_pkg::TMO_W-1:0] comm_timeout_q;
    logic [motor_ctrl_pkg::ERR_W-1:0] comm_err_lim_q;
    // block state
    logic [motor_ctrl_pkg::POS_W-1:0] cmd_pos_q;
    logic [ALM_W-1:0]                 alarm_q;
    logic [ALM_W-1:0]                 alarm_d;
    logic [ALM_W-1:0]                 alarm_set;
    logic [ALM_W-1:0]                 alarm_clr;
    logic [22:0]                      ovl_pre_q;
    logic [9:0]                       ovl_ticks_q;
    logic [14:0]                      ms_pre_q;
    logic [motor_ctrl_pkg::TMO_W-1:0] idle_ms_q;
    logic                             comm_armed_q;
    logic [motor_ctrl_pkg::ERR_W-1:0] err_cnt_q;
    logic [22:0]                      blink_cnt_q;
    logic                             led_q;
    logic                             warn_q;
    logic                             any_alarm;
    logic                             unlock;
    logic                             current_on;
    logic [31:0]                      rd_mux;
    logic [motor_ctrl_pkg::EDGE_N-1:0] edge_in;
    logic [motor_ctrl_pkg::EDGE_N-1:0] edge_rise;
    logic [motor_ctrl_pkg::EDGE_N-1:0] edge_fall;

    // one shared detector for every edge-triggered input
    assign edge_in = {EXCITE_IN, ABS_POSITION_FAULT_CLEAR_IN, FAULT_CLEAR_IN, PRESET_IN};

    edge_detect #(
        .WIDTH (motor_ctrl_pkg::EDGE_N)
    ) u_edges (
        .clk  (CLK),
        .nrst (NRST),
        .ce   (CE),
        .din  (edge_in),
        .rise (edge_rise),
        .fall (edge_fall)
    );

    // shared status terms
    assign any_alarm  = |alarm_q;
    assign current_on = EXCITE_IN && !any_alarm;
    // an unmapped source counts as on, so it cannot veto the other
    assign unlock = (!config_q[motor_ctrl_pkg::CFG_UNLOCK_DIR] || TOOL_UNLOCK_DIRECT_IN) &&
                    (!config_q[motor_ctrl_pkg::CFG_UNLOCK_REM] || TOOL_UNLOCK_REMOTE_IN);

    // register writes
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            preset_pos_q   <= motor_ctrl_pkg::PRESET_POS_RST;
            overload_thr_q <= motor_ctrl_pkg::OVERLOAD_THR_RST;
            dev_on_thr_q   <= motor_ctrl_pkg::DEV_ON_THR_RST;
            dev_off_thr_q  <= motor_ctrl_pkg::DEV_OFF_THR_RST;
            config_q       <= motor_ctrl_pkg::CONFIG_RST;
            comm_timeout_q <= motor_ctrl_pkg::COMM_TIMEOUT_RST;
            comm_err_lim_q <= motor_ctrl_pkg::COMM_ERR_LIM_RST;
        end
        else if (CE && WR)
        begin
            unique case (ADDR)
                motor_ctrl_pkg::REG_PRESET_POS:   preset_pos_q   <= WDATA[23:0];
                motor_ctrl_pkg::REG_OVERLOAD_THR: overload_thr_q <= WDATA[8:0];
                motor_ctrl_pkg::REG_DEV_ON_THR:   dev_on_thr_q   <= WDATA[14:0];
                motor_ctrl_pkg::REG_DEV_OFF_THR:  dev_off_thr_q  <= WDATA[14:0];
                motor_ctrl_pkg::REG_CONFIG:       config_q       <= WDATA[2:0];
                motor_ctrl_pkg::REG_COMM_TIMEOUT: comm_timeout_q <= WDATA[13:0];
                motor_ctrl_pkg::REG_COMM_ERR_LIM: comm_err_lim_q <= WDATA[3:0];
                default: ;   // read-only and unmapped offsets ignore writes
            endcase
        end
    end

    // read mux; unmapped offsets read as zero
    always_comb
    begin
        rd_mux = 32'h00000000;
        unique case (ADDR)
            motor_ctrl_pkg::REG_PRESET_POS:   rd_mux[23:0] = preset_pos_q;
            motor_ctrl_pkg::REG_OVERLOAD_THR: rd_mux[8:0]  = overload_thr_q;
            motor_ctrl_pkg::REG_DEV_ON_THR:   rd_mux[14:0] = dev_on_thr_q;
            motor_ctrl_pkg::REG_DEV_OFF_THR:  rd_mux[14:0] = dev_off_thr_q;
            motor_ctrl_pkg::REG_CONFIG:       rd_mux[2:0]  = config_q;
            motor_ctrl_pkg::REG_COMM_TIMEOUT: rd_mux[13:0] = comm_timeout_q;
            motor_ctrl_pkg::REG_COMM_ERR_LIM: rd_mux[3:0]  = comm_err_lim_q;
            motor_ctrl_pkg::REG_STATUS:
            begin
                rd_mux[ALM_W-1:0]                 = alarm_q;
                rd_mux[motor_ctrl_pkg::ST_WARN]   = warn_q;
                rd_mux[motor_ctrl_pkg::ST_CURR]   = MOTOR_CURRENT_OUT;
                rd_mux[motor_ctrl_pkg::ST_MOTION] = MOTION_ACTIVE_OUT;
                rd_mux[motor_ctrl_pkg::ST_UNLOCK] = TOOL_PERMIT_OUT;
            end
            motor_ctrl_pkg::REG_CMD_POS:      rd_mux[23:0] = cmd_pos_q;
            motor_ctrl_pkg::REG_COMM_ERR_CNT: rd_mux[3:0]  = err_cnt_q;
            default: ;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            RDATA <= 32'h00000000;
        else if (CE)
            RDATA <= RD ? rd_mux : 32'h00000000;
    end

    // preset: the motion flag is the registered operating indication
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            cmd_pos_q <= motor_ctrl_pkg::PRESET_POS_RST;
        else if (CE && edge_rise[motor_ctrl_pkg::EDGE_PRESET]
                 && !any_alarm && !MOTION_ACTIVE_OUT)
            cmd_pos_q <= preset_pos_q;
    end

    // overload timer counts whole 0.1 s units while overload persists
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            ovl_pre_q   <= 23'h000000;
            ovl_ticks_q <= 10'h000;
        end
        else if (CE)
        begin
            if (!OVERLOAD_IN)
            begin
                ovl_pre_q   <= 23'h000000;
                ovl_ticks_q <= 10'h000;
            end
            else if (ovl_pre_q == 23'(OVERLOAD_UNIT_CYC - 1))
            begin
                ovl_pre_q <= 23'h000000;
                if (ovl_ticks_q != 10'h3FF)   // saturate, never wrap back under threshold
                    ovl_ticks_q <= ovl_ticks_q + 10'h001;
            end
            else
                ovl_pre_q <= ovl_pre_q + 23'h000001;
        end
    end

    // serial idle timer in ms; armed by the first activity so power-up is quiet
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            ms_pre_q     <= 15'h0000;
            idle_ms_q    <= 14'h0000;
            comm_armed_q <= 1'b0;
        end
        else if (CE)
        begin
            if (COMM_ACTIVITY_IN)
            begin
                ms_pre_q     <= 15'h0000;
                idle_ms_q    <= 14'h0000;
                comm_armed_q <= 1'b1;
            end
            else
            begin
                if (alarm_set[motor_ctrl_pkg::ALM_COMM_TMO])
                    comm_armed_q <= 1'b0;   // one alarm per silence
                if (ms_pre_q == 15'(COMM_UNIT_CYC - 1))
                begin
                    ms_pre_q <= 15'h0000;
                    if (idle_ms_q != 14'h3FFF)
                        idle_ms_q <= idle_ms_q + 14'h0001;
                end
                else
                    ms_pre_q <= ms_pre_q + 15'h0001;
            end
        end
    end

    // serial error counter; restarts when the fault clear input falls
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            err_cnt_q <= 4'h0;
        else if (CE)
        begin
            if (edge_fall[motor_ctrl_pkg::EDGE_CLEAR])
                err_cnt_q <= COMM_ERROR_IN ? 4'h1 : 4'h0;   // a new error still counts
            else if (COMM_ERROR_IN && err_cnt_q != 4'hF)
                err_cnt_q <= err_cnt_q + 4'h1;
        end
    end

    // current-off deviation warning
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            warn_q <= 1'b0;
        else if (CE)
            warn_q <= !current_on && (DEVIATION_IN > dev_off_thr_q);
    end

    // alarm sources
    always_comb
    begin
        alarm_set = '0;
        alarm_set[motor_ctrl_pkg::ALM_OVERLOAD] =
            (ovl_ticks_q > {1'b0, overload_thr_q});
        alarm_set[motor_ctrl_pkg::ALM_DEV_ON] =
            current_on && (DEVIATION_IN > dev_on_thr_q);
        alarm_set[motor_ctrl_pkg::ALM_HOME] = config_q[motor_ctrl_pkg::CFG_RTH_EN] &&
            POSITIONING_START_IN && !ORIGIN_SET_IN;
        alarm_set[motor_ctrl_pkg::ALM_DEV_OFF] =
            warn_q && edge_rise[motor_ctrl_pkg::EDGE_EXCITE];
        alarm_set[motor_ctrl_pkg::ALM_COMM_TMO] = comm_armed_q && !COMM_ACTIVITY_IN &&
            (comm_timeout_q != 14'h0000) && (idle_ms_q >= comm_timeout_q);
        alarm_set[motor_ctrl_pkg::ALM_COMM_ERR] = !edge_fall[motor_ctrl_pkg::EDGE_CLEAR] &&
            (err_cnt_q >= comm_err_lim_q) && (comm_err_lim_q != 4'h0);
        alarm_set[motor_ctrl_pkg::ALM_ABS_POS] = ABS_POSITION_ERROR_IN;
    end

    // alarm clearing: fault clear hits resettable ones, abs clear only its own
    always_comb
    begin
        alarm_clr = '0;
        if (edge_fall[motor_ctrl_pkg::EDGE_CLEAR])
            alarm_clr = motor_ctrl_pkg::RESETTABLE_MASK;
        if (edge_fall[motor_ctrl_pkg::EDGE_ABSCLR] && alarm_q[motor_ctrl_pkg::ALM_ABS_POS])
            alarm_clr[motor_ctrl_pkg::ALM_ABS_POS] = 1'b1;
        alarm_d = (alarm_q & ~alarm_clr) | alarm_set;   // a fresh cause beats the clear
    end

    // sticky alarm flags
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            alarm_q <= '0;
        else if (CE)
            alarm_q <= alarm_d;
    end

    // led blink timer runs only while an alarm stands
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            blink_cnt_q <= 23'h000000;
            led_q       <= 1'b0;
        end
        else if (CE)
        begin
            if (!(|alarm_d))
            begin
                blink_cnt_q <= 23'h000000;
                led_q       <= 1'b0;
            end
            else if (!any_alarm || blink_cnt_q == 23'(BLINK_HALF_CYC - 1))
            begin
                blink_cnt_q <= 23'h000000;
                led_q       <= !any_alarm ? 1'b1 : !led_q;   // lit in the alarm's first cycle
            end
            else
                blink_cnt_q <= blink_cnt_q + 23'h000001;
        end
    end

    // registered outputs; fault pins and motor current switched from the next alarm state together
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            FAULT_DIRECT_OUT  <= 1'b1;
            FAULT_REMOTE_OUT  <= 1'b0;
            MOTOR_CURRENT_OUT <= 1'b0;
            MOTION_ACTIVE_OUT <= 1'b0;
            DEV_OFF_WARN_OUT  <= 1'b0;
            TOOL_PERMIT_OUT   <= 1'b0;
        end
        else if (CE)
        begin
            FAULT_DIRECT_OUT  <= !(|alarm_d);
            FAULT_REMOTE_OUT  <= |alarm_d;
            MOTOR_CURRENT_OUT <= EXCITE_IN && !(|alarm_d);
            MOTION_ACTIVE_OUT <= MOTION_IN;
            DEV_OFF_WARN_OUT  <= !current_on && (DEVIATION_IN > dev_off_thr_q);
            TOOL_PERMIT_OUT   <= unlock;
        end
    end

    assign ALARM_LED_OUT    = led_q;
    assign CMD_POSITION_OUT = cmd_pos_q;
endmodule // motor_preset_alarm_control

//--- test/motor_ctrl_checker.sv
// port-level assertions for the motor preset and alarm control block
`timescale 1ns/10ps
module motor_ctrl_checker (
    // clock, reset, enable
    input wire logic        CLK,
    input wire logic        NRST,
    input wire logic        CE,
    // observed inputs
    input wire logic        PRESET_IN,
    input wire logic        FAULT_CLEAR_IN,
    input wire logic        ABS_POSITION_FAULT_CLEAR_IN,
    input wire logic        EXCITE_IN,
    input wire logic        MOTION_IN,
    // observed outputs
    input wire logic [23:0] CMD_POSITION_OUT,
    input wire logic        FAULT_DIRECT_OUT,
    input wire logic        FAULT_REMOTE_OUT,
    input wire logic        ALARM_LED_OUT,
    input wire logic        MOTOR_CURRENT_OUT,
    input wire logic        MOTION_ACTIVE_OUT
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    // both fault pins carry one alarm state in opposite senses
    a_fault_pins_opposite: assert property (
        FAULT_DIRECT_OUT != FAULT_REMOTE_OUT) else $error("fault outputs agree");
    // an alarm always removes motor current
    a_alarm_cuts_current: assert property (
        FAULT_REMOTE_OUT |-> !MOTOR_CURRENT_OUT) else $error("current on during alarm");
    // current follows excitation one cycle later unless an alarm stands
    a_current_follows: assert property (
        $past(CE) && $past(NRST) |-> MOTOR_CURRENT_OUT == ($past(EXCITE_IN) && !FAULT_REMOTE_OUT))
        else $error("motor current wrong");
    // motion output is the registered motion level
    a_motion_copy: assert property (
        $past(CE) && $past(NRST) |-> MOTION_ACTIVE_OUT == $past(MOTION_IN))
        else $error("motion output wrong");
    // led dark without alarm, lit in the first alarm cycle
    a_led_dark: assert property (
        !FAULT_REMOTE_OUT |-> !ALARM_LED_OUT) else $error("led lit without alarm");
    a_led_starts: assert property (
        $rose(FAULT_REMOTE_OUT) |-> ALARM_LED_OUT) else $error("led not lit on alarm");
    // command position moves only on an accepted preset rise
    a_preset_only: assert property (
        $changed(CMD_POSITION_OUT) |-> $past(PRESET_IN) && !$past(PRESET_IN, 2)
        && !$past(MOTION_ACTIVE_OUT) && !$past(FAULT_REMOTE_OUT))
        else $error("command position moved without preset");
    // alarms vanish only after a falling edge of a clear input
    a_clear_on_fall: assert property (
        $fell(FAULT_REMOTE_OUT) |-> (!$past(FAULT_CLEAR_IN) && $past(FAULT_CLEAR_IN, 2))
        || (!$past(ABS_POSITION_FAULT_CLEAR_IN) && $past(ABS_POSITION_FAULT_CLEAR_IN, 2)))
        else $error("alarm cleared without clear fall");

    // main scenarios reached
    c_preset: cover property ($changed(CMD_POSITION_OUT));
    c_cleared: cover property ($fell(FAULT_REMOTE_OUT));
    c_current: cover property ($rose(MOTOR_CURRENT_OUT));
endmodule // motor_ctrl_checker

//--- test/host_model.sv
// host controller model driving the discrete command and serial event pins
`timescale 1ns/10ps
module host_model (
    // clock
    input wire logic clk,
    // pins toward the device
    output logic     preset_in,
    output logic     fault_clear_in,
    output logic     abs_clear_in,
    output logic     comm_activity_in,
    output logic     comm_error_in
);
    logic [4:0] pins_q = 5'h00;

    // one vector keeps every pin change on a clock edge
    assign {comm_error_in, comm_activity_in, abs_clear_in, fault_clear_in, preset_in} = pins_q;

    // set one pin level right after an edge
    task automatic level(input int idx, input logic v);
        @(posedge clk);
        pins_q[idx] <= v;
    endtask

    // each level stands a full cycle so the device sees one rise and one fall
    task automatic pulse(input int idx);
        level(idx, 1'b1);
        level(idx, 1'b0);
        @(posedge clk);
    endtask
endmodule // host_model

//--- test/tb_motor_preset_alarm_control.sv
// testbench for the motor preset and alarm control block
`timescale 1ns/10ps
module tb_motor_preset_alarm_control;
    logic        CLK, NRST, CE, WR, RD, EXC, MOT, OVL, PST, ORG, ABE, UND, UNR;
    logic        PRE, FCL, ACL, CAC, CER, FDO, FRO, LED, CUR, MAO, WRN, PRM;
    logic [7:0]  ADDR;
    logic [31:0] WDATA, RDATA;
    logic [14:0] DEV;
    logic [23:0] CMD;
    logic [22:0] pin_q = 23'h000000;
    // discrete pins and deviation move as one vector, so one edge changes them together
    assign {DEV, UNR, UND, ABE, ORG, PST, OVL, MOT, EXC} = pin_q;
    int          bad_count = 0;
    int          total_checks = 0;
    logic [7:0]  ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h18, 8'h30};
    logic [31:0] rv [7] = '{32'h0, 32'h32, 32'h12C, 32'h2710, 32'h0, 32'h3, 32'h0};

    motor_preset_alarm_control #(.OVERLOAD_UNIT_CYC(10), .COMM_UNIT_CYC(5), .BLINK_HALF_CYC(4))
    i_motor_preset_alarm_control (.CLK(CLK), .NRST(NRST), .CE(CE), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .PRESET_IN(PRE), .FAULT_CLEAR_IN(FCL),
        .ABS_POSITION_FAULT_CLEAR_IN(ACL), .TOOL_UNLOCK_DIRECT_IN(UND),
        .TOOL_UNLOCK_REMOTE_IN(UNR), .EXCITE_IN(EXC), .MOTION_IN(MOT), .OVERLOAD_IN(OVL),
        .DEVIATION_IN(DEV), .POSITIONING_START_IN(PST), .ORIGIN_SET_IN(ORG),
        .ABS_POSITION_ERROR_IN(ABE), .COMM_ACTIVITY_IN(CAC), .COMM_ERROR_IN(CER),
        .CMD_POSITION_OUT(CMD), .FAULT_DIRECT_OUT(FDO), .FAULT_REMOTE_OUT(FRO),
        .ALARM_LED_OUT(LED), .MOTOR_CURRENT_OUT(CUR), .MOTION_ACTIVE_OUT(MAO),
        .DEV_OFF_WARN_OUT(WRN), .TOOL_PERMIT_OUT(PRM));
    host_model i_host_model (.clk(CLK), .preset_in(PRE), .fault_clear_in(FCL),
        .abs_clear_in(ACL), .comm_activity_in(CAC), .comm_error_in(CER));

    // 20 MHz clock
    initial
    begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    // m selects the stimulus bits, v gives their new levels
    task automatic drv(input logic [22:0] m, input logic [22:0] v);
        @(posedge CLK);
        pin_q <= (pin_q & ~m) | v;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge CLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        check("read data", RDATA & m, e);
    endtask
    task automatic fault_out(input logic [6:0] e);
        rd(motor_ctrl_pkg::REG_STATUS, 32'h7F, {25'h0, e});
        check("fault pin", {31'h0, FRO}, {31'h0, |e});
    endtask
    task automatic clr();
        i_host_model.pulse(1);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // hang guard, far beyond the few hundred cycles the sequence needs
    initial
    begin
        #(20000 * 50);
        bad_count++;
        final_report();
    end

    initial
    begin
        {NRST, WR, RD} = 3'h0;
        {CE, ADDR, WDATA} = {1'b1, 8'h00, 32'h0};
        repeat (10) @(posedge CLK);
        NRST <= 1'b1;
        step(2);
        for (int i = 0; i < 7; i++)
            rd(ra[i], 32'hFFFFFFFF, rv[i]);
        check("permit", {31'h0, PRM}, 32'h1);
        check("direct fault", {31'h0, FDO}, 32'h1);
        // preset at the negative limit, then refused while moving
        wr(motor_ctrl_pkg::REG_PRESET_POS, 32'h00800000);
        i_host_model.pulse(0);
        check("cmd", {8'h0, CMD}, 32'h00800000);
        drv(23'h2, 23'h2);
        wr(motor_ctrl_pkg::REG_PRESET_POS, 32'h007FFFFF);
        i_host_model.pulse(0);
        check("cmd", {8'h0, CMD}, 32'h00800000);
        drv(23'h2, 23'h0);
        step(2);
        i_host_model.pulse(0);
        check("cmd", {8'h0, CMD}, 32'h007FFFFF);
        // overload beyond two units of 0.1 s
        wr(motor_ctrl_pkg::REG_OVERLOAD_THR, 32'h2);
        drv(23'h5, 23'h5);
        step(25);
        check("current", {31'h0, CUR}, 32'h1);
        check("direct fault", {31'h0, FDO}, 32'h1);
        step(15);
        fault_out(7'h01);
        check("current", {31'h0, CUR}, 32'h0);
        wr(motor_ctrl_pkg::REG_PRESET_POS, 32'h0);
        i_host_model.pulse(0);
        check("cmd", {8'h0, CMD}, 32'h007FFFFF);
        drv(23'h4, 23'h0);
        i_host_model.level(1, 1'b1);
        step(2);
        fault_out(7'h01);
        i_host_model.level(1, 1'b0);
        step(1);
        fault_out(7'h00);
        // absolute position alarm ignores the plain clear
        drv(23'h20, 23'h20);
        drv(23'h20, 23'h0);
        clr();
        fault_out(7'h40);
        i_host_model.pulse(2);
        fault_out(7'h00);
        // serial error count reaching the default limit of three
        i_host_model.pulse(4);
        i_host_model.pulse(4);
        fault_out(7'h00);
        i_host_model.pulse(4);
        fault_out(7'h20);
        clr();
        fault_out(7'h00);
        // serial timeout of 3 ms, then monitoring off
        wr(motor_ctrl_pkg::REG_COMM_TIMEOUT, 32'h3);
        i_host_model.pulse(3);
        step(8);
        fault_out(7'h00);
        step(10);
        fault_out(7'h10);
        wr(motor_ctrl_pkg::REG_COMM_TIMEOUT, 32'h0);
        clr();
        i_host_model.pulse(3);
        step(30);
        fault_out(7'h00);
        // deviation with current on, at and above the default
        drv(23'h7FFF00, 23'h12C00);
        step(3);
        fault_out(7'h00);
        drv(23'h7FFF00, 23'h12D00);
        fault_out(7'h02);
        drv(23'h7FFF00, 23'h0);
        clr();
        // deviation with current off warns, excitation escalates
        drv(23'h7FFF01, 23'h271100);
        step(3);
        check("warning", {31'h0, WRN}, 32'h1);
        drv(23'h7FFF01, 23'h1);
        fault_out(7'h08);
        clr();
        // positioning start with and without an origin
        wr(motor_ctrl_pkg::REG_CONFIG, 32'h1);
        drv(23'h18, 23'h18);
        drv(23'h8, 23'h0);
        fault_out(7'h00);
        drv(23'h18, 23'h8);
        drv(23'h8, 23'h0);
        fault_out(7'h04);
        clr();
        // tool unlock mapped on direct, then on both sources
        wr(motor_ctrl_pkg::REG_CONFIG, 32'h2);
        step(2);
        check("permit", {31'h0, PRM}, 32'h0);
        drv(23'h40, 23'h40);
        step(2);
        check("permit", {31'h0, PRM}, 32'h1);
        wr(motor_ctrl_pkg::REG_CONFIG, 32'h6);
        step(2);
        check("permit", {31'h0, PRM}, 32'h0);
        drv(23'h80, 23'h80);
        step(2);
        check("permit", {31'h0, PRM}, 32'h1);
        final_report();
    end
endmodule // tb_motor_preset_alarm_control

bind motor_preset_alarm_control motor_ctrl_checker i_motor_ctrl_checker (.CLK(CLK),
    .NRST(NRST), .CE(CE), .PRESET_IN(PRESET_IN), .FAULT_CLEAR_IN(FAULT_CLEAR_IN),
    .ABS_POSITION_FAULT_CLEAR_IN(ABS_POSITION_FAULT_CLEAR_IN), .EXCITE_IN(EXCITE_IN),
    .MOTION_IN(MOTION_IN), .CMD_POSITION_OUT(CMD_POSITION_OUT),
    .FAULT_DIRECT_OUT(FAULT_DIRECT_OUT), .FAULT_REMOTE_OUT(FAULT_REMOTE_OUT),
    .ALARM_LED_OUT(ALARM_LED_OUT), .MOTOR_CURRENT_OUT(MOTOR_CURRENT_OUT),
    .MOTION_ACTIVE_OUT(MOTION_ACTIVE_OUT));
